// ---- rtl/core_status_pointer_pkg.sv ----
// Constants for the core status and pointer special registers
package core_status_pointer_pkg;
   // Special register byte addresses
   localparam logic [7:0] ADDR_STACK_TOP   = 8'h81;
   localparam logic [7:0] ADDR_IND_LOW     = 8'h82;
   localparam logic [7:0] ADDR_IND_HIGH    = 8'h83;
   localparam logic [7:0] ADDR_STATUS_WORD = 8'hd0;
   localparam logic [7:0] ADDR_OPERAND     = 8'he0;
   // Reset values
   localparam logic [7:0] RST_STACK_TOP    = 8'h07;
   localparam logic [7:0] RST_IND_LOW      = 8'h00;
   localparam logic [7:0] RST_IND_HIGH     = 8'h00;
   localparam logic [7:0] RST_STATUS_WORD  = 8'h00;
   localparam logic [7:0] RST_OPERAND      = 8'h00;
   // Status word field positions
   localparam int         POS_CARRY        = 7;
   localparam int         POS_NIBBLE       = 6;
   localparam int         POS_USER_A       = 5;
   localparam int         POS_BANK_HI      = 4;
   localparam int         POS_BANK_LO      = 3;
   localparam int         POS_WRAP         = 2;
   localparam int         POS_USER_B       = 1;
   localparam int         POS_PARITY       = 0;
   // Bit-addressable registers have these low three address bits
   localparam logic [2:0] BIT_ADDR_LOW     = 3'h0;
   // Special register space starts here
   localparam logic [7:0] SFR_BASE         = 8'h80;
   // Largest unsigned multiply result that does not overflow
   localparam logic [15:0] MUL_LIMIT       = 16'h00ff;
endpackage : core_status_pointer_pkg

// ---- rtl/core_status_pointer_regs.sv ----
// Stack pointer, indirect pointer, accumulator and status word registers
//
// Function
// [RULE1] The stack top pointer holds the top of stack and is incremented before each push write.
// [RULE2] Reset loads the stack top pointer with 0x07.
// [RULE3] The low and high indirect pointer bytes together form one 16-bit flash pointer.
// [RULE4] Carry is set by a carry or borrow of the last arithmetic operation, else cleared by it.
// [RULE5] Nibble carry is set by a carry into or borrow from the upper nibble, else cleared.
// [RULE6] Status bits 5 and 1 are user flags changed only by software byte or bit writes.
// [RULE7] Status bits 4:3 select the register bank at base 0x00, 0x08, 0x10 or 0x18.
// [RULE8] Signed wrap flag is set by sign overflow, multiply above 255 or divide by zero.
// [RULE9] Those same instructions clear the signed wrap flag when no overflow occurs.
// [RULE10] Status bit 0 is read-only and shows odd parity of the accumulator.
// [RULE11] The accumulator is the eight-bit arithmetic operand register and resets to zero.
// [RULE12] Software never writes a one into a reserved bit.
// [RULE13] Special addresses without a register here do nothing and read as zero.
// [RULE14] A push increments the pointer and then the value goes to the new pointer address.
// [RULE15] Each bank is eight byte registers and only the selected bank is active.
// [RULE16] Status word and accumulator are reachable by bit as well as by byte.
// [RULE17] Writes to the parity bit are ignored; it tracks the accumulator in the same cycle.
`timescale 1ns/10ps
module core_status_pointer_regs (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Special register byte access
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr_en,
   input  wire logic [7:0]  sfr_wr_data,
   output logic      [7:0]  sfr_rd_data,
   output logic             sfr_rd_hit,
   // Special register bit access
   input  wire logic [7:0]  sfr_bit_addr,
   input  wire logic        sfr_bit_wr_en,
   input  wire logic        sfr_bit_wr_val,
   output logic             sfr_bit_rd_data,
   // Datapath: stack
   input  wire logic        push_en,
   input  wire logic        pop_en,
   // Datapath: accumulator
   input  wire logic        acc_wr_en,
   input  wire logic [7:0]  acc_wr_data,
   // Datapath: indirect pointer
   input  wire logic        ptr_wr_en,
   input  wire logic [15:0] ptr_wr_data,
   input  wire logic        ptr_inc_en,
   // Datapath: flags
   input  wire logic        arith_en,
   input  wire logic        arith_carry,
   input  wire logic        arith_nibble_carry,
   input  wire logic        wrap_add_en,
   input  wire logic        wrap_add_ovf,
   input  wire logic        wrap_mul_en,
   input  wire logic [15:0] wrap_mul_result,
   input  wire logic        wrap_div_en,
   input  wire logic [7:0]  wrap_div_divisor,
   // Register views
   output logic      [7:0]  stack_top_pointer,
   output logic      [15:0] indirect_pointer_word,
   output logic      [7:0]  main_operand_reg,
   output logic      [7:0]  processor_status_word,
   output logic      [4:0]  bank_base
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0] sp;
      logic [7:0] ind_low;
      logic [7:0] ind_high;
      logic [7:0] acc;
      logic       carry_flag;
      logic       nibble_carry_flag;
      logic       user_flag_a;
      logic       bank_select_hi;
      logic       bank_select_lo;
      logic       signed_wrap_flag;
      logic       user_flag_b;
      logic       parity;
      logic [7:0] rd_data;
      logic       rd_hit;
      logic       bit_rd;
   } state_t;

   state_t     state_reg;
   state_t     state_next;
   logic [7:0] psw_now;
   logic [7:0] bit_byte;
   logic [7:0] psw_wr;
   logic [7:0] acc_wr;
   logic [15:0] ptr_sum;
   logic        wrap_any_en;
   logic        wrap_val;
   logic [7:0]  bit_src;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      psw_now  = {state_reg.carry_flag, state_reg.nibble_carry_flag, state_reg.user_flag_a,
                  state_reg.bank_select_hi, state_reg.bank_select_lo,
                  state_reg.signed_wrap_flag, state_reg.user_flag_b, state_reg.parity};
      bit_byte = {sfr_bit_addr[7:3], core_status_pointer_pkg::BIT_ADDR_LOW};
      psw_wr   = psw_now;
      acc_wr   = state_reg.acc;
      ptr_sum  = 16'h0000;
      wrap_any_en = wrap_add_en | wrap_mul_en | wrap_div_en;
      wrap_val    = 1'b0;
      bit_src     = 8'h00;
      state_next  = state_reg;

      // Software byte writes
      if (sfr_wr_en) begin
         case (sfr_addr)
            core_status_pointer_pkg::ADDR_STACK_TOP:   state_next.sp = sfr_wr_data;
            core_status_pointer_pkg::ADDR_IND_LOW:     state_next.ind_low = sfr_wr_data;
            core_status_pointer_pkg::ADDR_IND_HIGH:    state_next.ind_high = sfr_wr_data;
            core_status_pointer_pkg::ADDR_STATUS_WORD: psw_wr = sfr_wr_data;
            core_status_pointer_pkg::ADDR_OPERAND:     acc_wr = sfr_wr_data;
            // [RULE13] Unmapped writes dropped
            default: ;
         endcase
      end

      // [RULE16] Bit writes to status word
      if (sfr_bit_wr_en && bit_byte == core_status_pointer_pkg::ADDR_STATUS_WORD) begin
         psw_wr[sfr_bit_addr[2:0]] = sfr_bit_wr_val;
      end
      // [RULE16] Bit writes to accumulator
      if (sfr_bit_wr_en && bit_byte == core_status_pointer_pkg::ADDR_OPERAND) begin
         acc_wr[sfr_bit_addr[2:0]] = sfr_bit_wr_val;
      end

      // [RULE6] User flags from software only
      state_next.user_flag_a       = psw_wr[core_status_pointer_pkg::POS_USER_A];
      state_next.user_flag_b       = psw_wr[core_status_pointer_pkg::POS_USER_B];
      // [RULE7] Bank select from software
      state_next.bank_select_hi    = psw_wr[core_status_pointer_pkg::POS_BANK_HI];
      state_next.bank_select_lo    = psw_wr[core_status_pointer_pkg::POS_BANK_LO];
      state_next.carry_flag        = psw_wr[core_status_pointer_pkg::POS_CARRY];
      state_next.nibble_carry_flag = psw_wr[core_status_pointer_pkg::POS_NIBBLE];
      state_next.signed_wrap_flag  = psw_wr[core_status_pointer_pkg::POS_WRAP];

      // [RULE4] Carry from arithmetic
      if (arith_en) begin
         state_next.carry_flag = arith_carry;
      end
      // [RULE5] Nibble carry from arithmetic
      if (arith_en) begin
         state_next.nibble_carry_flag = arith_nibble_carry;
      end

      // [RULE8] Overflow conditions
      if (wrap_add_en) begin
         wrap_val = wrap_add_ovf;
      end else if (wrap_mul_en) begin
         wrap_val = wrap_mul_result > core_status_pointer_pkg::MUL_LIMIT;
      end else if (wrap_div_en) begin
         wrap_val = wrap_div_divisor == 8'h00;
      end
      // [RULE9] Cleared when no overflow
      if (wrap_any_en) begin
         state_next.signed_wrap_flag = wrap_val;
      end

      // [RULE11] Accumulator update, datapath wins
      state_next.acc = acc_wr_en ? acc_wr_data : acc_wr;
      // [RULE10] [RULE17] Parity follows new accumulator
      state_next.parity = ^state_next.acc;

      // [RULE1] [RULE14] Pre-increment on push
      if (push_en) begin
         state_next.sp = state_reg.sp + 8'h01;
      end else if (pop_en) begin
         state_next.sp = state_reg.sp - 8'h01;
      end

      // [RULE3] Pointer load or step as one word
      if (ptr_wr_en) begin
         state_next.ind_high = ptr_wr_data[15:8];
         state_next.ind_low  = ptr_wr_data[7:0];
      end else if (ptr_inc_en) begin
         ptr_sum             = {state_reg.ind_high, state_reg.ind_low} + 16'h0001;
         state_next.ind_high = ptr_sum[15:8];
         state_next.ind_low  = ptr_sum[7:0];
      end

      // [RULE13] Read decode, unmapped reads zero
      state_next.rd_hit = 1'b1;
      case (sfr_addr)
         core_status_pointer_pkg::ADDR_STACK_TOP:   state_next.rd_data = state_reg.sp;
         core_status_pointer_pkg::ADDR_IND_LOW:     state_next.rd_data = state_reg.ind_low;
         core_status_pointer_pkg::ADDR_IND_HIGH:    state_next.rd_data = state_reg.ind_high;
         core_status_pointer_pkg::ADDR_STATUS_WORD: state_next.rd_data = psw_now;
         core_status_pointer_pkg::ADDR_OPERAND:     state_next.rd_data = state_reg.acc;
         default: begin
            state_next.rd_data = 8'h00;
            state_next.rd_hit  = 1'b0;
         end
      endcase

      // [RULE16] Bit reads
      case (bit_byte)
         core_status_pointer_pkg::ADDR_STATUS_WORD: bit_src = psw_now;
         core_status_pointer_pkg::ADDR_OPERAND:     bit_src = state_reg.acc;
         default:                                   bit_src = 8'h00;
      endcase
      state_next.bit_rd = bit_src[sfr_bit_addr[2:0]];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // [RULE2] Stack pointer reset value
         state_reg.sp                <= core_status_pointer_pkg::RST_STACK_TOP;
         state_reg.ind_low           <= core_status_pointer_pkg::RST_IND_LOW;
         state_reg.ind_high          <= core_status_pointer_pkg::RST_IND_HIGH;
         state_reg.acc               <= core_status_pointer_pkg::RST_OPERAND;
         state_reg.carry_flag        <= 1'b0;
         state_reg.nibble_carry_flag <= 1'b0;
         state_reg.user_flag_a       <= 1'b0;
         state_reg.bank_select_hi    <= 1'b0;
         state_reg.bank_select_lo    <= 1'b0;
         state_reg.signed_wrap_flag  <= 1'b0;
         state_reg.user_flag_b       <= 1'b0;
         state_reg.parity            <= 1'b0;
         state_reg.rd_data           <= 8'h00;
         state_reg.rd_hit            <= 1'b0;
         state_reg.bit_rd            <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign stack_top_pointer     = state_reg.sp;
   assign indirect_pointer_word = {state_reg.ind_high, state_reg.ind_low};
   assign main_operand_reg      = state_reg.acc;
   assign processor_status_word = psw_now;
   // [RULE15] One active bank base
   assign bank_base             = {state_reg.bank_select_hi, state_reg.bank_select_lo, 3'h0};
   assign sfr_rd_data           = state_reg.rd_data;
   assign sfr_rd_hit            = state_reg.rd_hit;
   assign sfr_bit_rd_data       = state_reg.bit_rd;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_push_inc;
      @(posedge clk) disable iff (!rst_n)
      push_en |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01;
   endproperty
   a_push_inc: assert property (p_push_inc) else $error("Push did not increment"); // [RULE1]

   property p_reset_sp;
      @(posedge clk) $rose(rst_n) |-> stack_top_pointer == 8'h07;
   endproperty
   a_reset_sp: assert property (p_reset_sp) else $error("Bad stack reset value"); // [RULE2]

   property p_ptr_inc;
      @(posedge clk) disable iff (!rst_n)
      (ptr_inc_en && !ptr_wr_en) |=>
         indirect_pointer_word == $past(indirect_pointer_word) + 16'h0001;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("Pointer step wrong"); // [RULE3]

   property p_carry;
      @(posedge clk) disable iff (!rst_n)
      arith_en |=> processor_status_word[7] == $past(arith_carry);
   endproperty
   a_carry: assert property (p_carry) else $error("Carry not from arithmetic"); // [RULE4]

   property p_nibble;
      @(posedge clk) disable iff (!rst_n)
      arith_en |=> processor_status_word[6] == $past(arith_nibble_carry);
   endproperty
   a_nibble: assert property (p_nibble) else $error("Nibble carry wrong"); // [RULE5]

   property p_user_hold;
      @(posedge clk) disable iff (!rst_n)
      (!sfr_wr_en && !sfr_bit_wr_en) |=>
         $stable({processor_status_word[5], processor_status_word[1]});
   endproperty
   a_user_hold: assert property (p_user_hold) else $error("User flag changed by hw"); // [RULE6]

   property p_bank;
      @(posedge clk) disable iff (!rst_n)
      (sfr_wr_en && sfr_addr == 8'hd0 && !sfr_bit_wr_en) |=>
         bank_base == {$past(sfr_wr_data[4:3]), 3'h0};
   endproperty
   a_bank: assert property (p_bank) else $error("Bank base mismatch"); // [RULE7]

   property p_mul_ovf;
      @(posedge clk) disable iff (!rst_n)
      (wrap_mul_en && !wrap_add_en) |=>
         processor_status_word[2] == ($past(wrap_mul_result) > 16'h00ff);
   endproperty
   a_mul_ovf: assert property (p_mul_ovf) else $error("Multiply overflow wrong"); // [RULE8]

   property p_div_ovf;
      @(posedge clk) disable iff (!rst_n)
      (wrap_div_en && !wrap_add_en && !wrap_mul_en) |=>
         processor_status_word[2] == ($past(wrap_div_divisor) == 8'h00);
   endproperty
   a_div_ovf: assert property (p_div_ovf) else $error("Divide overflow wrong"); // [RULE9]

   property p_parity;
      @(posedge clk) disable iff (!rst_n)
      processor_status_word[0] == ^main_operand_reg;
   endproperty
   a_parity: assert property (p_parity) else $error("Parity wrong"); // [RULE10]

   property p_acc_load;
      @(posedge clk) disable iff (!rst_n)
      acc_wr_en |=> main_operand_reg == $past(acc_wr_data);
   endproperty
   a_acc_load: assert property (p_acc_load) else $error("Accumulator load lost"); // [RULE11]

   property p_unmapped;
      @(posedge clk) disable iff (!rst_n)
      (sfr_addr == 8'h97) |=> (sfr_rd_data == 8'h00 && !sfr_rd_hit);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero"); // [RULE13]

endmodule : core_status_pointer_regs

// ---- verification/alu_partner.sv ----
// Behavioural arithmetic datapath feeding results and flags to the registers
`timescale 1ns/10ps
module alu_partner (
   input  wire logic       go,
   input  wire logic       sub,
   input  wire logic       cin,
   input  wire logic [7:0] op_a,
   input  wire logic [7:0] op_b,
   output logic            acc_wr_en,
   output logic [7:0]      acc_wr_data,
   output logic            arith_en,
   output logic            arith_carry,
   output logic            arith_nibble_carry,
   output logic            wrap_add_en,
   output logic            wrap_add_ovf
);
   logic [8:0] full;
   logic [4:0] low;
   logic       ovf;
   // Data and flag outputs carry garbage outside an operation; the enables are low
   always_comb begin
      full = sub ? {1'b0, op_a} - {1'b0, op_b} - 9'(cin) : {1'b0, op_a} + {1'b0, op_b} + 9'(cin);
      low = sub ? {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - 5'(cin)
                : {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + 5'(cin);
      ovf = (sub ? op_a[7] != op_b[7] : op_a[7] == op_b[7]) && (full[7] != op_a[7]);
      acc_wr_en = go;
      arith_en = go;
      wrap_add_en = go;
      acc_wr_data = go ? full[7:0] : ~full[7:0];
      arith_carry = go ? full[8] : ~full[8];
      arith_nibble_carry = go ? low[4] : ~low[4];
      wrap_add_ovf = go ? ovf : ~ovf;
   end
endmodule : alu_partner

// ---- verification/testbench.sv ----
// Self-checking bench for the core status and pointer registers
`timescale 1ns/10ps
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, go = 1'b0, sub = 1'b0, cin = 1'b0;
   logic [7:0]  sfr_addr = 8'h00, sfr_wr_data = 8'h00, sfr_bit_addr = 8'h00;
   logic [7:0]  op_a = 8'h00, op_b = 8'h00, wrap_div_divisor = 8'h00;
   logic        sfr_wr_en = 1'b0, sfr_bit_wr_en = 1'b0, sfr_bit_wr_val = 1'b0;
   logic        push_en = 1'b0, pop_en = 1'b0, ptr_wr_en = 1'b0, ptr_inc_en = 1'b0;
   logic        wrap_mul_en = 1'b0, wrap_div_en = 1'b0;
   logic [15:0] ptr_wr_data = 16'h0000, wrap_mul_result = 16'h0000, m_ptr;
   logic        acc_wr_en, arith_en, arith_carry, arith_nibble_carry, wrap_add_en, wrap_add_ovf;
   logic        sfr_rd_hit, sfr_bit_rd_data, exp_bit;
   logic [7:0]  acc_wr_data, sfr_rd_data, stack_top_pointer, main_operand_reg;
   logic [7:0]  processor_status_word, m_sp, m_acc, m_psw;
   logic [15:0] indirect_pointer_word;
   logic [4:0]  bank_base;
   logic [31:0] seed = 32'h000046d3;
   logic [7:0]  tbl [8] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'h97, 8'hae, 8'hf5};
   int          err_count = 0, checks_done = 0, cycles = 0, s, n, v;

   alu_partner u_alu (.go(go), .sub(sub), .cin(cin), .op_a(op_a), .op_b(op_b),
      .acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data), .arith_en(arith_en),
      .arith_carry(arith_carry), .arith_nibble_carry(arith_nibble_carry),
      .wrap_add_en(wrap_add_en), .wrap_add_ovf(wrap_add_ovf));
   core_status_pointer_regs dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
      .sfr_wr_en(sfr_wr_en), .sfr_wr_data(sfr_wr_data), .sfr_rd_data(sfr_rd_data),
      .sfr_rd_hit(sfr_rd_hit), .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wr_en(sfr_bit_wr_en),
      .sfr_bit_wr_val(sfr_bit_wr_val), .sfr_bit_rd_data(sfr_bit_rd_data), .push_en(push_en),
      .pop_en(pop_en), .acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data),
      .ptr_wr_en(ptr_wr_en), .ptr_wr_data(ptr_wr_data), .ptr_inc_en(ptr_inc_en),
      .arith_en(arith_en), .arith_carry(arith_carry), .arith_nibble_carry(arith_nibble_carry),
      .wrap_add_en(wrap_add_en), .wrap_add_ovf(wrap_add_ovf), .wrap_mul_en(wrap_mul_en),
      .wrap_mul_result(wrap_mul_result), .wrap_div_en(wrap_div_en),
      .wrap_div_divisor(wrap_div_divisor), .stack_top_pointer(stack_top_pointer),
      .indirect_pointer_word(indirect_pointer_word), .main_operand_reg(main_operand_reg),
      .processor_status_word(processor_status_word), .bank_base(bank_base));

   always #2 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd
   task automatic results();
      if (err_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic model_reset();
      m_sp = 8'h07;
      m_ptr = 16'h0000;
      m_acc = 8'h00;
      m_psw = 8'h00;
   endtask : model_reset
   task automatic views();
      chk(stack_top_pointer, m_sp);
      chk(indirect_pointer_word, m_ptr);
      chk(main_operand_reg, m_acc);
      chk(processor_status_word, {m_psw[7:1], ^m_acc});
      chk(bank_base, {m_psw[4:3], 3'h0});
   endtask : views
   task automatic rd(input logic [7:0] a);
      logic [8:0] e;
      case (a)
         8'h81:   e = {1'b1, m_sp};
         8'h82:   e = {1'b1, m_ptr[7:0]};
         8'h83:   e = {1'b1, m_ptr[15:8]};
         8'hd0:   e = {1'b1, m_psw[7:1], ^m_acc};
         8'he0:   e = {1'b1, m_acc};
         default: e = 9'h000;
      endcase
      sfr_addr = a;
      step();
      chk(sfr_rd_data, e[7:0]);
      chk(sfr_rd_hit, e[8]);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wr_data = d;
      sfr_wr_en = 1'b1;
      step();
      sfr_wr_en = 1'b0;
      case (a)
         8'h81:   m_sp = d;
         8'h82:   m_ptr[7:0] = d;
         8'h83:   m_ptr[15:8] = d;
         8'hd0:   m_psw = {d[7:1], 1'b0};
         8'he0:   m_acc = d;
         default: ;
      endcase
      views();
      step();
   endtask : wr
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         results();
      end
   end
   always @(negedge clk) begin
      if (rst_n) chk(processor_status_word[0], ^main_operand_reg);
   end
   initial begin
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      model_reset();
      views();
      // Reads and writes of every register and reserved places
      for (int i = 0; i < 8; i++) begin
         rd(tbl[i]);
         wr(tbl[i], i < 5 ? rnd() : 8'h00);
         rd(tbl[i]);
      end
      wr(8'h81, 8'hfe);
      push_en = 1'b1;
      for (int i = 0; i < 3; i++) begin
         step();
         m_sp++;
         views();
      end
      push_en = 1'b0;
      pop_en = 1'b1;
      step();
      pop_en = 1'b0;
      m_sp--;
      views();
      ptr_wr_data = 16'h00ff;
      ptr_wr_en = 1'b1;
      step();
      ptr_wr_en = 1'b0;
      ptr_inc_en = 1'b1;
      step();
      ptr_inc_en = 1'b0;
      m_ptr = 16'h0100;
      views();
      go = 1'b1;
      for (int i = 0; i < 40; i++) begin
         {op_a, op_b, sub, cin} = {rnd(), rnd(), rnd() > 8'h7f, rnd() > 8'h7f};
         step();
         s = sub ? int'(op_a) - int'(op_b) - int'(cin) : int'(op_a) + int'(op_b) + int'(cin);
         n = sub ? int'(op_a[3:0]) - int'(op_b[3:0]) - int'(cin)
                 : int'(op_a[3:0]) + int'(op_b[3:0]) + int'(cin);
         v = sub ? int'($signed(op_a)) - int'($signed(op_b)) - int'(cin)
                 : int'($signed(op_a)) + int'($signed(op_b)) + int'(cin);
         m_acc = s[7:0];
         m_psw[7] = s < 0 || s > 255;
         m_psw[6] = n < 0 || n > 15;
         m_psw[2] = v < -128 || v > 127;
         views();
      end
      go = 1'b0;
      wrap_mul_en = 1'b1;
      for (int i = 0; i < 2; i++) begin
         wrap_mul_result = i == 0 ? 16'h0100 : 16'h00ff;
         step();
         m_psw[2] = i == 0;
         views();
      end
      wrap_mul_en = 1'b0;
      wrap_div_en = 1'b1;
      for (int i = 0; i < 2; i++) begin
         wrap_div_divisor = i == 0 ? 8'h00 : rnd() | 8'h01;
         step();
         m_psw[2] = i == 0;
         views();
      end
      wrap_div_en = 1'b0;
      for (int b = 0; b < 4; b++) wr(8'hd0, {m_psw[7:5], 2'(b), m_psw[2:0]});
      tbl = '{8'hd5, 8'hd1, 8'hd0, 8'he3, 8'hd7, 8'he0, 8'h82, 8'hd4};
      for (int i = 0; i < 8; i++) begin
         sfr_bit_addr = tbl[i];
         sfr_bit_wr_val = rnd() > 8'h7f;
         sfr_bit_wr_en = 1'b1;
         step();
         sfr_bit_wr_en = 1'b0;
         if (tbl[i][7:3] == 5'h1a && tbl[i][2:0] != 3'h0) m_psw[tbl[i][2:0]] = sfr_bit_wr_val;
         if (tbl[i][7:3] == 5'h1c) m_acc[tbl[i][2:0]] = sfr_bit_wr_val;
         views();
         step();
         exp_bit = tbl[i][7:3] == 5'h1c ? m_acc[tbl[i][2:0]] : 1'b0;
         if (tbl[i][7:3] == 5'h1a) exp_bit = tbl[i][2:0] == 3'h0 ? ^m_acc : m_psw[tbl[i][2:0]];
         chk(sfr_bit_rd_data, exp_bit);
      end
      rst_n = 1'b0;
      step();
      rst_n = 1'b1;
      model_reset();
      views();
      results();
   end
endmodule : testbench
